// ### logic/evng_top.sv
// Event notification generator: per-source enables, event queue, message output, Wishbone slave
//
// Our own choices: the Wishbone register port and the register addresses.
`include "evng_regs.svh"

module evng_top #(
    parameter bit COLOR_MODEL = 1'b1,
    parameter int FRAME_W = 32,
    parameter int QUEUE_DEPTH = 16,
    parameter int QUEUE_AW = 4
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Event conditions and stamps
    input wire logic [evng_pkg::NUM_SRC-1:0] EVT_PULSE,
    input wire logic [63:0] TIMESTAMP,
    input wire logic [FRAME_W-1:0] FRAME_SEQUENCE_NUMBER,
    // Message stream
    output logic MSG_VALID,
    input wire logic MSG_READY,
    output logic [15:0] MSG_EVENT_TYPE_CODE,
    output logic [63:0] MSG_TIMESTAMP,
    output logic [FRAME_W-1:0] MSG_FRAME_SEQUENCE_NUMBER,
    // Interrupt
    output logic IRQ
);

    localparam int NS = evng_pkg::NUM_SRC;
    localparam int BW = NS + 64 + FRAME_W;
    localparam logic [NS-1:0] SUPPORTED = COLOR_MODEL ? {NS{1'b1}} : ~`EVNG_COLOR_ONLY_MASK;

    // ----------------------------------------------------------------
    // Code table
    // ----------------------------------------------------------------
    // Monochrome exposure begin/finish sit at the green indices, codes line up
    localparam evng_pkg::evng_code_t CODES [NS] = '{
        `EVNG_CODE_CAPTURE_BEGIN, `EVNG_CODE_CAPTURE_FINISH,
        `EVNG_CODE_FRAME_BEGIN, `EVNG_CODE_FRAME_FINISH,
        `EVNG_CODE_RED_BEGIN, `EVNG_CODE_RED_FINISH,
        `EVNG_CODE_GREEN_BEGIN, `EVNG_CODE_GREEN_FINISH,
        `EVNG_CODE_BLUE_BEGIN, `EVNG_CODE_BLUE_FINISH,
        `EVNG_CODE_LINE_BEGIN, `EVNG_CODE_LINE_FINISH};

    // ----------------------------------------------------------------
    // Register bus decode
    // ----------------------------------------------------------------
    logic [`EVNG_SEL_W-1:0] select_reg;
    logic [NS-1:0] notify_enable_reg;
    logic [`EVNG_INT_W-1:0] int_status_reg;
    logic [`EVNG_INT_W-1:0] int_mask_reg;
    logic [15:0] last_code_reg;
    logic [63:0] last_ts_reg;
    logic [FRAME_W-1:0] last_frame_reg;
    logic bus_go;
    logic bus_wr;
    logic bus_rd;
    logic sel_mapped;
    logic [3:0] sel_idx;
    logic [31:0] rd_next;
    assign bus_go = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign bus_wr = bus_go && WB_WE_I && WB_SEL_I[0];
    assign bus_rd = bus_go && !WB_WE_I;

    always_comb
    begin
        sel_mapped = 1'b1;
        case (select_reg)
            `EVNG_SELCODE_LINE_BEGIN: sel_idx = `EVNG_IDX_LINE_BEGIN;
            `EVNG_SELCODE_LINE_FINISH: sel_idx = `EVNG_IDX_LINE_FINISH;
            default:
            begin
                sel_mapped = select_reg <= `EVNG_SELCODE_LAST_DIRECT;
                sel_idx = sel_mapped ? select_reg[3:0] : 4'h0;
            end
        endcase
        sel_mapped = sel_mapped && SUPPORTED[sel_idx];
    end

    // ----------------------------------------------------------------
    // Queue bookkeeping
    // ----------------------------------------------------------------
    logic [QUEUE_AW:0] wptr_reg;
    logic [QUEUE_AW:0] rptr_reg;
    logic [QUEUE_AW:0] level;
    logic q_full;
    logic q_empty;
    logic [NS-1:0] fired;
    logic push;
    logic pop;
    logic [BW-1:0] rd_data;
    assign level = wptr_reg - rptr_reg;
    assign q_full = level == QUEUE_DEPTH[QUEUE_AW:0];
    assign q_empty = level == '0;
    assign fired = EVT_PULSE & notify_enable_reg & SUPPORTED;
    assign push = |fired && !q_full;

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end
        else
        begin
            wptr_reg <= wptr_reg + (QUEUE_AW + 1)'(push);
            rptr_reg <= rptr_reg + (QUEUE_AW + 1)'(pop);
        end
    end

    // Stamps are frozen in the same cycle as the condition
    evng_queue_mem #(
        .WIDTH(BW),
        .DEPTH(QUEUE_DEPTH),
        .AW(QUEUE_AW)
    ) u_queue (
        .clk(CLK),
        .wr_en(push),
        .wr_addr(wptr_reg[QUEUE_AW-1:0]),
        .wr_data({fired, TIMESTAMP, FRAME_SEQUENCE_NUMBER}),
        .rd_en(pop),
        .rd_addr(rptr_reg[QUEUE_AW-1:0]),
        .rd_data(rd_data)
    );

    // ----------------------------------------------------------------
    // Message serialiser
    // ----------------------------------------------------------------
    evng_pkg::evng_state_t state_reg;
    logic [NS-1:0] batch_reg;
    logic [63:0] batch_ts_reg;
    logic [FRAME_W-1:0] batch_frame_reg;
    logic [3:0] low_idx;
    logic sending;
    assign pop = (state_reg == evng_pkg::ST_IDLE) && !q_empty;
    // One bubble per message keeps the handshake simple
    assign sending = (state_reg == evng_pkg::ST_SEND) && !MSG_VALID && |batch_reg;

    // Lowest index first for events of the same cycle
    always_comb
    begin
        low_idx = 4'h0;
        for (int i = NS - 1; i >= 0; i--)
        begin
            if (batch_reg[i])
            begin
                low_idx = 4'(i);
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state_reg <= evng_pkg::ST_IDLE;
            batch_reg <= '0;
            batch_ts_reg <= '0;
            batch_frame_reg <= '0;
        end
        else
        begin
            case (state_reg)
                evng_pkg::ST_IDLE:
                begin
                    state_reg <= pop ? evng_pkg::ST_READ : evng_pkg::ST_IDLE;
                end
                evng_pkg::ST_READ:
                begin
                    {batch_reg, batch_ts_reg, batch_frame_reg} <= rd_data;
                    state_reg <= evng_pkg::ST_SEND;
                end
                evng_pkg::ST_SEND:
                begin
                    if (sending)
                    begin
                        batch_reg[low_idx] <= 1'b0;
                    end
                    else if (!MSG_VALID && batch_reg == '0)
                    begin
                        state_reg <= evng_pkg::ST_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= evng_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            MSG_VALID <= 1'b0;
            MSG_EVENT_TYPE_CODE <= '0;
            MSG_TIMESTAMP <= '0;
            MSG_FRAME_SEQUENCE_NUMBER <= '0;
            last_code_reg <= '0;
            last_ts_reg <= '0;
            last_frame_reg <= '0;
        end
        else if (sending)
        begin
            MSG_VALID <= 1'b1;
            MSG_EVENT_TYPE_CODE <= CODES[low_idx];
            MSG_TIMESTAMP <= batch_ts_reg;
            MSG_FRAME_SEQUENCE_NUMBER <= batch_frame_reg;
            last_code_reg <= CODES[low_idx];
            last_ts_reg <= batch_ts_reg;
            last_frame_reg <= batch_frame_reg;
        end
        else if (MSG_VALID && MSG_READY)
        begin
            MSG_VALID <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            select_reg <= `EVNG_SEL_RESET;
            int_mask_reg <= `EVNG_INT_RESET;
        end
        else if (bus_wr && WB_ADR_I == `EVNG_OFS_SELECT)
        begin
            select_reg <= WB_DAT_I[`EVNG_SEL_W-1:0];
        end
        else if (bus_wr && WB_ADR_I == `EVNG_OFS_INT_MASK)
        begin
            int_mask_reg <= WB_DAT_I[`EVNG_INT_W-1:0];
        end
    end

    // Only the selected source's enable is touched
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            notify_enable_reg <= {NS{`EVNG_NOTIFY_OFF}};
        end
        else if (bus_wr && WB_ADR_I == `EVNG_OFS_NOTIFY && sel_mapped)
        begin
            notify_enable_reg[sel_idx] <= WB_DAT_I[`EVNG_NOTIFY_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status, cleared by read, set wins
    // ----------------------------------------------------------------
    logic [`EVNG_INT_W-1:0] int_set;
    logic status_rd;
    assign status_rd = bus_rd && WB_ADR_I == `EVNG_OFS_INT_STATUS;

    always_comb
    begin
        int_set = '0;
        int_set[`EVNG_INT_QUEUED_BIT] = push;
        int_set[`EVNG_INT_OVERFLOW_BIT] = |fired && q_full;
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            int_status_reg <= `EVNG_INT_RESET;
            IRQ <= 1'b0;
        end
        else
        begin
            int_status_reg <= (status_rd ? '0 : int_status_reg) | int_set;
            IRQ <= |(int_status_reg & int_mask_reg);
        end
    end

    // ----------------------------------------------------------------
    // Read mux and acknowledge
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_next = '0;
        case (WB_ADR_I)
            `EVNG_OFS_SELECT: rd_next[`EVNG_SEL_W-1:0] = select_reg;
            `EVNG_OFS_NOTIFY: rd_next[`EVNG_NOTIFY_BIT] = sel_mapped && notify_enable_reg[sel_idx];
            `EVNG_OFS_ENABLE_MAP: rd_next[NS-1:0] = notify_enable_reg;
            `EVNG_OFS_INT_STATUS: rd_next[`EVNG_INT_W-1:0] = int_status_reg;
            `EVNG_OFS_INT_MASK: rd_next[`EVNG_INT_W-1:0] = int_mask_reg;
            `EVNG_OFS_LAST_CODE: rd_next[15:0] = last_code_reg;
            `EVNG_OFS_LAST_TS_LO: rd_next = last_ts_reg[31:0];
            `EVNG_OFS_LAST_TS_HI: rd_next = last_ts_reg[63:32];
            `EVNG_OFS_LAST_FRAME: rd_next[FRAME_W-1:0] = last_frame_reg;
            `EVNG_OFS_QUEUE_LEVEL: rd_next[QUEUE_AW:0] = level;
            default: rd_next = '0;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end
        else
        begin
            WB_ACK_O <= bus_go;
            if (bus_rd)
            begin
                WB_DAT_O <= rd_next;
            end
        end
    end

endmodule

// ### logic/evng_regs.svh
// Register offsets, field positions, reset values and event codes for the event generator
`ifndef EVNG_REGS_SVH
`define EVNG_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define EVNG_OFS_SELECT 8'h00
`define EVNG_OFS_NOTIFY 8'h04
`define EVNG_OFS_ENABLE_MAP 8'h08
`define EVNG_OFS_INT_STATUS 8'h0c
`define EVNG_OFS_INT_MASK 8'h10
`define EVNG_OFS_LAST_CODE 8'h14
`define EVNG_OFS_LAST_TS_LO 8'h18
`define EVNG_OFS_LAST_TS_HI 8'h1c
`define EVNG_OFS_LAST_FRAME 8'h20
`define EVNG_OFS_QUEUE_LEVEL 8'h24

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define EVNG_SEL_W 5
`define EVNG_SEL_RESET 5'h00
`define EVNG_NOTIFY_BIT 0
`define EVNG_NOTIFY_OFF 1'b0
`define EVNG_NOTIFY_ON 1'b1
`define EVNG_INT_QUEUED_BIT 0
`define EVNG_INT_OVERFLOW_BIT 1
`define EVNG_INT_W 2
`define EVNG_INT_RESET 2'h0

// ----------------------------------------------------------------
// Source selector codes
// ----------------------------------------------------------------
`define EVNG_SELCODE_LINE_BEGIN 5'h1c
`define EVNG_SELCODE_LINE_FINISH 5'h1d
`define EVNG_SELCODE_LAST_DIRECT 5'h09
`define EVNG_IDX_LINE_BEGIN 4'ha
`define EVNG_IDX_LINE_FINISH 4'hb

// ----------------------------------------------------------------
// Event type codes, by source index
// ----------------------------------------------------------------
`define EVNG_CODE_CAPTURE_BEGIN 16'h9011
`define EVNG_CODE_CAPTURE_FINISH 16'h9012
`define EVNG_CODE_FRAME_BEGIN 16'h9300
`define EVNG_CODE_FRAME_FINISH 16'h9301
`define EVNG_CODE_RED_BEGIN 16'h9302
`define EVNG_CODE_RED_FINISH 16'h9303
`define EVNG_CODE_GREEN_BEGIN 16'h9304
`define EVNG_CODE_GREEN_FINISH 16'h9305
`define EVNG_CODE_BLUE_BEGIN 16'h9306
`define EVNG_CODE_BLUE_FINISH 16'h9307
`define EVNG_CODE_LINE_BEGIN 16'h9330
`define EVNG_CODE_LINE_FINISH 16'h9331

// Sources 4,5,8,9 exist only on the colour variant
`define EVNG_COLOR_ONLY_MASK 12'h330

`endif

// ### logic/evng_pkg.sv
// Types shared by the event generator
package evng_pkg;

    localparam int NUM_SRC = 12;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_SEND = 3'b100
    } evng_state_t;

    typedef logic [15:0] evng_code_t;

endpackage

// ### logic/evng_queue_mem.sv
// Simple dual-port memory holding queued event batches, registered read data
module evng_queue_mem #(
    parameter int WIDTH = 108,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // Read port
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rd_en)
        begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

// ### dv/evng_chk.sv
// Port assertions for the event generator
module evng_chk #(
    parameter int FRAME_W = 32
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // Bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // Messages
    input wire logic MSG_VALID,
    input wire logic MSG_READY,
    input wire logic [15:0] MSG_EVENT_TYPE_CODE,
    input wire logic [63:0] MSG_TIMESTAMP,
    input wire logic [FRAME_W-1:0] MSG_FRAME_SEQUENCE_NUMBER,
    input wire logic IRQ
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    property p_ack_answer;
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not acked");
    property p_ack_pulse;
        WB_ACK_O |=> !WB_ACK_O;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_sel_field;
        WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h00 |-> WB_DAT_O[31:5] == 27'h0;
    endproperty
    a_sel_field: assert property (p_sel_field) else $error("selector too wide");
    property p_msg_hold;
        MSG_VALID && !MSG_READY |=> MSG_VALID && $stable(MSG_EVENT_TYPE_CODE)
            && $stable(MSG_TIMESTAMP) && $stable(MSG_FRAME_SEQUENCE_NUMBER);
    endproperty
    a_msg_hold: assert property (p_msg_hold) else $error("message lost");
    property p_msg_gap;
        MSG_VALID && MSG_READY |=> !MSG_VALID;
    endproperty
    a_msg_gap: assert property (p_msg_gap) else $error("no idle cycle");
    property p_code_set;
        MSG_VALID |-> MSG_EVENT_TYPE_CODE inside {16'h9011, 16'h9012, [16'h9300:16'h9307],
            16'h9330, 16'h9331};
    endproperty
    a_code_set: assert property (p_code_set) else $error("bad type code");
    property p_reset;
        disable iff (1'b0)
        SYS_RST |=> !MSG_VALID && !IRQ && MSG_TIMESTAMP == 64'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared");
    property p_quiet;
        $fell(SYS_RST) |-> !MSG_VALID [*5];
    endproperty
    a_quiet: assert property (p_quiet) else $error("message while off");

    c_stall: cover property (MSG_VALID && !MSG_READY);
    c_irq: cover property ($rose(IRQ));
    c_b2b: cover property (MSG_VALID && MSG_READY ##2 MSG_VALID);
endmodule

bind evng_top evng_chk #(.FRAME_W(FRAME_W)) u_chk (.CLK(CLK), .SYS_RST(SYS_RST),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .MSG_VALID(MSG_VALID), .MSG_READY(MSG_READY),
    .MSG_EVENT_TYPE_CODE(MSG_EVENT_TYPE_CODE), .MSG_TIMESTAMP(MSG_TIMESTAMP),
    .MSG_FRAME_SEQUENCE_NUMBER(MSG_FRAME_SEQUENCE_NUMBER), .IRQ(IRQ));

// ### dv/evng_host.sv
// Host model taking event messages, fast or stalling
module evng_host (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Stall control and handshake
    input wire logic slow,
    output logic msg_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase_reg;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            phase_reg <= 2'h0;
            msg_ready <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_reg + 2'h1;
            // One accept in four lets batches pile up in the queue
            msg_ready <= !slow || phase_reg == 2'h3;
        end
    end
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the event generator
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, cyc, stb, we, ack, irq, mvalid, mready, slow;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w, dat_r, rd, fr, mfr, lfsr_reg, last_fr;
    logic [11:0] evt, b;
    logic [63:0] ts, mts;
    logic [15:0] mcode, last_code;
    logic [111:0] e;
    logic [111:0] exp_q[$];
    int n_fail, total_checks;
    logic [15:0] codes[12] = '{16'h9011, 16'h9012, 16'h9300, 16'h9301, 16'h9302,
        16'h9303, 16'h9304, 16'h9305, 16'h9306, 16'h9307, 16'h9330, 16'h9331};
    logic [4:0] sels[12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
        5'h08, 5'h09, 5'h1c, 5'h1d};
    logic [7:0] ofs[11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
        8'h20, 8'h24, 8'h3c};

    evng_top i_dut (.CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r),
        .WB_ACK_O(ack), .EVT_PULSE(evt), .TIMESTAMP(ts), .FRAME_SEQUENCE_NUMBER(fr),
        .MSG_VALID(mvalid), .MSG_READY(mready), .MSG_EVENT_TYPE_CODE(mcode),
        .MSG_TIMESTAMP(mts), .MSG_FRAME_SEQUENCE_NUMBER(mfr), .IRQ(irq));
    evng_host i_host (.clk(clk), .rst(rst), .slow(slow), .msg_ready(mready));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string name, input logic [63:0] x, input logic [63:0] g);
        total_checks++;
        if (g !== x)
        begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", name, x, g);
        end
    endtask

    task automatic chk_msg(input logic [111:0] x);
        chk("code", x[111:96], mcode);
        chk("stamp", x[95:32], mts);
        chk("frame", x[31:0], mfr);
    endtask

    // Classic cycle; entered and left just after a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do
        begin
            @(negedge clk);
            n++;
            if (n > 20)
            begin
                n_fail++;
                end_sim();
            end
        end
        while (ack !== 1'b1);
        @(posedge clk);
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic fire(input logic [11:0] bits, input logic [11:0] en);
        lfsr_reg = lfsr(lfsr_reg);
        ts <= {lfsr_reg, ~lfsr_reg};
        fr <= lfsr_reg;
        evt <= bits;
        for (int i = 0; i < 12; i++)
            if (bits[i] && en[i])
            begin
                exp_q.push_back({codes[i], lfsr_reg, ~lfsr_reg, lfsr_reg});
                last_code = codes[i];
                last_fr = lfsr_reg;
            end
        @(posedge clk);
    endtask

    task automatic drain();
        int n;
        n = 0;
        evt <= 12'h0;
        do
        begin
            @(negedge clk);
            n++;
            if (n > 3000)
            begin
                n_fail++;
                end_sim();
            end
        end
        while (exp_q.size() != 0 || mvalid === 1'b1);
        repeat (8) @(posedge clk);
    endtask

    // ----------------------------------------------------------------
    // Message monitor
    // ----------------------------------------------------------------
    always @(negedge clk)
        if (!rst && mvalid === 1'b1 && mready === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("extra_msg", 0, 1);
            else
            begin
                e = exp_q.pop_front();
                chk_msg(e);
            end
        end

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {rst, cyc, stb, we, slow, adr, dat_w, evt, ts, fr} = '0;
        sel = 4'hf;
        rst = 1'b1;
        lfsr_reg = 32'hc18d;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (ofs[i])
        begin
            wb(1'b0, ofs[i], 32'h0);
            chk("reset_reg", 0, rd);
        end
        fire(12'hfff, 12'h000);
        drain();
        foreach (sels[i])
        begin
            wb(1'b1, 8'h00, {27'h0, sels[i]});
            wb(1'b1, 8'h04, 32'h1);
        end
        wb(1'b1, 8'h00, 32'h1);
        wb(1'b1, 8'h04, 32'h0);
        wb(1'b0, 8'h08, 32'h0);
        chk("enable_map", 32'hffd, rd);
        wb(1'b1, 8'h00, 32'h1d);
        wb(1'b0, 8'h04, 32'h0);
        chk("notify_1d", 1, rd);
        wb(1'b1, 8'h00, 32'h0a);
        wb(1'b0, 8'h04, 32'h0);
        chk("notify_0a", 0, rd);
        sel <= 4'he;
        wb(1'b1, 8'h00, 32'h3);
        sel <= 4'hf;
        wb(1'b0, 8'h00, 32'h0);
        chk("sel_ignored", 32'ha, rd);
        wb(1'b1, 8'h10, 32'h1);
        for (int i = 0; i < 12; i++)
            fire(12'h1 << i, 12'hffd);
        drain();
        slow <= 1'b1;
        for (int k = 0; k < 6; k++)
        begin
            b = lfsr_reg[11:0];
            fire(b, 12'hffd);
        end
        drain();
        slow <= 1'b0;
        wb(1'b0, 8'h14, 32'h0);
        chk("last_code", last_code, rd);
        wb(1'b0, 8'h20, 32'h0);
        chk("last_frame", last_fr, rd);
        chk("irq_set", 1, irq);
        wb(1'b0, 8'h0c, 32'h0);
        chk("status", 1, rd);
        @(negedge clk);
        chk("irq_clear", 0, irq);
        wb(1'b1, 8'h10, 32'h0);
        fire(12'h004, 12'hffd);
        drain();
        chk("irq_masked", 0, irq);
        wb(1'b0, 8'h0c, 32'h0);
        chk("status_masked", 1, rd);
        end_sim();
    end
endmodule
